// [hw/ring_freq_pkg.sv]
package ring_freq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RING_VAL_CTRL3 = 8'h18;
    localparam logic [7:0] OFS_RING_VAL_CTRL2 = 8'h40;
    localparam logic [7:0] OFS_RING_MAX       = 8'h44;
    localparam logic [7:0] OFS_RING_STATUS    = 8'h48;
    localparam logic [7:0] OFS_IRQ_STATUS     = 8'h4c;
    localparam logic [7:0] OFS_IRQ_MASK       = 8'h50;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          CHECK_EN_BIT       = 7;
    localparam int          RSVD_BIT           = 6;
    localparam int          ASSERT_W           = 6;
    localparam logic [7:0]  CTRL3_RESET        = 8'h19;
    localparam logic [7:0]  CTRL2_RESET        = 8'h2d;
    localparam logic [5:0]  MAX_COUNT_RESET    = 6'h0c;
    localparam int          DELAY_HI_BIT       = 7;
    localparam int          TIMEOUT_LSB        = 3;
    localparam int          CONFIRM_LSB        = 0;
    localparam int          IRQ_W              = 4;
    localparam int          IRQ_VALID          = 0;
    localparam int          IRQ_LOW            = 1;
    localparam int          IRQ_HIGH           = 2;
    localparam int          IRQ_END            = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ             = 40_000_000;
    localparam int          STEP_US            = 2000;
    localparam int          STEP_CYCLES        = CLK_HZ / 1_000_000 * STEP_US;
    localparam int          TIMEOUT_STEP_MS    = 128;
    localparam int          DELAY_STEP_MS      = 256;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_QUALIFY,
        ST_DELAY,
        ST_VALID
    } ring_state_e;

    typedef struct packed {
        logic       enable;
        logic [5:0] assert_time;
        logic [2:0] confirm_sel;
        logic [3:0] timeout_sel;
        logic [2:0] delay_sel;
        logic [5:0] max_count;
    } ring_cfg_s;

endpackage

// [hw/ring_frequency_validator.sv]
`timescale 1ns/1ps
`default_nettype none
module ring_frequency_validator
    import ring_freq_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic        ring_event_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             ring_valid_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]          ctrl3_ff;
    logic [7:0]          ctrl2_ff;
    logic [5:0]          max_ff;
    logic [IRQ_W-1:0]    irq_stat_ff;
    logic [IRQ_W-1:0]    irq_mask_ff;
    logic                wait_ff;
    logic [31:0]         rdata_ff;
    ring_state_e         state_ff;
    ring_cfg_s           cfg;
    logic                req;
    logic                wr_take;
    logic                rd_take;
    logic                wr_ctrl3;
    logic                wr_ctrl2;
    logic                wr_max;
    logic                wr_mask;
    logic                wr_irq;

    // ------------------------------------------------------------
    // Access decode: read taken first, write on answer edge
    // ------------------------------------------------------------
    assign req      = (avs_read_i || avs_write_i) && wait_ff;
    assign wr_take  = avs_write_i && !wait_ff;
    assign rd_take  = avs_read_i && wait_ff;
    assign wr_ctrl3 = wr_take && (avs_address_i == OFS_RING_VAL_CTRL3);
    assign wr_ctrl2 = wr_take && (avs_address_i == OFS_RING_VAL_CTRL2);
    assign wr_max   = wr_take && (avs_address_i == OFS_RING_MAX);
    assign wr_mask  = wr_take && (avs_address_i == OFS_IRQ_MASK);
    assign wr_irq   = wr_take && (avs_address_i == OFS_IRQ_STATUS);

    assign cfg.enable      = ctrl3_ff[CHECK_EN_BIT];
    assign cfg.assert_time = ctrl3_ff[ASSERT_W-1:0];
    assign cfg.confirm_sel = ctrl2_ff[CONFIRM_LSB+:3];
    assign cfg.timeout_sel = ctrl2_ff[TIMEOUT_LSB+:4];
    assign cfg.delay_sel   = {ctrl2_ff[DELAY_HI_BIT], 2'b00};
    assign cfg.max_count   = max_ff;

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, answer on second edge
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !req;
        end
    end

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o    = rdata_ff;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_ff <= 32'h0;
        end else if (rd_take) begin
            unique case (avs_address_i)
                OFS_RING_VAL_CTRL3: rdata_ff <= {24'h0, ctrl3_ff};
                OFS_RING_VAL_CTRL2: rdata_ff <= {24'h0, ctrl2_ff};
                OFS_RING_MAX:       rdata_ff <= {26'h0, max_ff};
                OFS_RING_STATUS:    rdata_ff <= {28'h0, ring_valid_o, state_ff == ST_QUALIFY, 2'(state_ff)};
                OFS_IRQ_STATUS:     rdata_ff <= {28'h0, irq_stat_ff};
                OFS_IRQ_MASK:       rdata_ff <= {28'h0, irq_mask_ff};
                default:            rdata_ff <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register writes, one block per register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl3_ff <= CTRL3_RESET;
        end else if (wr_ctrl3) begin
            ctrl3_ff <= avs_writedata_i[7:0] & 8'hbf;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl2_ff <= CTRL2_RESET;
        end else if (wr_ctrl2) begin
            ctrl2_ff <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            max_ff <= MAX_COUNT_RESET;
        end else if (wr_max) begin
            max_ff <= avs_writedata_i[5:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_mask_ff <= '0;
        end else if (wr_mask) begin
            irq_mask_ff <= avs_writedata_i[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // 2 ms step tick
    // ------------------------------------------------------------
    logic [31:0] pre_ff;
    logic        tick_ff;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !cfg.enable) begin
            pre_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else if (pre_ff == 32'(STEP_CYC - 1)) begin
            pre_ff  <= 32'h0;
            tick_ff <= 1'b1;
        end else begin
            pre_ff  <= pre_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Selection tables, in 2 ms steps
    // ------------------------------------------------------------
    function automatic logic [9:0] confirm_steps(input logic [2:0] s);
        unique case (s)
            3'h0: confirm_steps = 10'd50;
            3'h1: confirm_steps = 10'd75;
            3'h2: confirm_steps = 10'd100;
            3'h3: confirm_steps = 10'd128;
            3'h4: confirm_steps = 10'd192;
            3'h5: confirm_steps = 10'd256;
            3'h6: confirm_steps = 10'd320;
            3'h7: confirm_steps = 10'd512;
        endcase
    endfunction

    function automatic logic [9:0] delay_steps(input logic [2:0] s);
        unique case (s)
            3'h0:    delay_steps = 10'd0;
            3'h1:    delay_steps = 10'(DELAY_STEP_MS / 2);
            3'h2:    delay_steps = 10'(DELAY_STEP_MS);
            default: delay_steps = 10'(7 * DELAY_STEP_MS / 2);
        endcase
    endfunction

    // ------------------------------------------------------------
    // Qualification state machine
    // ------------------------------------------------------------
    logic [5:0]  ival_ff;
    logic [9:0]  conf_ff;
    logic [9:0]  end_ff;
    logic        too_low;
    logic        too_high;
    logic        ended;
    logic        go_valid;
    logic [IRQ_W-1:0] ev;

    assign too_low  = ring_event_i && (ival_ff == 6'h0);
    assign too_high = ring_event_i && (ival_ff > cfg.max_count);
    assign ended    = (state_ff != ST_IDLE) && (end_ff == 10'h0);
    assign go_valid = (state_ff == ST_DELAY) && (conf_ff == 10'h0) && !ended;

    // ------------------------------------------------------------
    // Interval and ring-end timers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !cfg.enable) begin
            ival_ff <= 6'h0;
        end else if (ring_event_i) begin
            ival_ff <= cfg.assert_time;
        end else if (tick_ff && ival_ff != 6'h0) begin
            ival_ff <= ival_ff - 6'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !cfg.enable) begin
            end_ff <= 10'h0;
        end else if (ring_event_i) begin
            end_ff <= 10'(cfg.timeout_sel) * 10'(TIMEOUT_STEP_MS / 2);
        end else if (tick_ff && end_ff != 10'h0) begin
            end_ff <= end_ff - 10'h1;
        end
    end

    // ------------------------------------------------------------
    // Qualification states
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !cfg.enable) begin
            state_ff <= ST_IDLE;
            conf_ff  <= 10'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (ring_event_i) begin
                        state_ff <= ST_QUALIFY;
                        conf_ff  <= confirm_steps(cfg.confirm_sel);
                    end
                end
                ST_QUALIFY: begin
                    if (too_low || too_high || ended) begin
                        state_ff <= ST_IDLE;
                    end else if (conf_ff == 10'h0) begin
                        state_ff <= ST_DELAY;
                        conf_ff  <= delay_steps(cfg.delay_sel);
                    end else if (tick_ff) begin
                        conf_ff  <= conf_ff - 10'h1;
                    end
                end
                ST_DELAY: begin
                    if (ended) begin
                        state_ff <= ST_IDLE;
                    end else if (conf_ff == 10'h0) begin
                        state_ff <= ST_VALID;
                    end else if (tick_ff) begin
                        conf_ff  <= conf_ff - 10'h1;
                    end
                end
                ST_VALID: begin
                    if (ended) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Valid-ring indication
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !cfg.enable) begin
            ring_valid_o <= 1'b0;
        end else if (go_valid) begin
            ring_valid_o <= 1'b1;
        end else if (state_ff == ST_VALID && ended) begin
            ring_valid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupts: set wins over write-one-to-clear
    // ------------------------------------------------------------
    always_comb begin
        ev            = '0;
        ev[IRQ_VALID] = go_valid && cfg.enable;
        ev[IRQ_LOW]   = (state_ff == ST_QUALIFY) && too_low && cfg.enable;
        ev[IRQ_HIGH]  = (state_ff == ST_QUALIFY) && too_high && !too_low && cfg.enable;
        ev[IRQ_END]   = (state_ff == ST_VALID) && ended && cfg.enable;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_stat_ff <= '0;
        end else if (wr_irq) begin
            irq_stat_ff <= (irq_stat_ff & ~avs_writedata_i[IRQ_W-1:0]) | ev;
        end else begin
            irq_stat_ff <= irq_stat_ff | ev;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule
`default_nettype wire

// [testbench/ring_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ring_line_model (
    input  wire logic       sys_clk_i,
    input  wire logic       run_i,
    input  wire logic [7:0] gap_i,
    output logic            ring_event_o
);
    logic [7:0] cnt_ff;
    // Two crossings per ring cycle, one pulse per half period
    always_ff @(posedge sys_clk_i) begin
        if (!run_i) begin
            cnt_ff       <= 8'h00;
            ring_event_o <= 1'b0;
        end else begin
            ring_event_o <= (cnt_ff == 8'h00);
            cnt_ff       <= (cnt_ff == 8'h00) ? gap_i - 8'h01 : cnt_ff - 8'h01;
        end
    end
endmodule
`default_nettype wire

// [testbench/ring_freq_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ring_freq_chk
    import ring_freq_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES
) (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        ring_event_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        ring_valid_o,
    input wire logic        irq_o
);
    localparam int LIMIT = 1000 * STEP_CYC;
    logic [7:0]  ctrl_ff;
    logic [3:0]  mask_ff;
    logic [1:0]  ev_ff;
    logic [31:0] gap_ff;
    wire         req = avs_read_i || avs_write_i;
    wire         wr_go = avs_write_i && !avs_waitrequest_o;
    wire         rd_ctl = avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_RING_VAL_CTRL3;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) ctrl_ff <= CTRL3_RESET;
        else if (wr_go && avs_address_i == OFS_RING_VAL_CTRL3) ctrl_ff <= {avs_writedata_i[7], 1'b0, avs_writedata_i[5:0]};
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) mask_ff <= 4'h0;
        else if (wr_go && avs_address_i == OFS_IRQ_MASK) mask_ff <= avs_writedata_i[3:0];
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !ctrl_ff[7]) ev_ff <= 2'd0;
        else if (ring_event_i && ev_ff != 2'd2) ev_ff <= ev_ff + 2'd1;
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || ring_event_i) gap_ff <= 32'h0;
        else if (gap_ff < LIMIT) gap_ff <= gap_ff + 32'h1;
    end
    ctrl_read_a: assert property (rd_ctl |-> avs_readdata_o == {24'h0, ctrl_ff})
        else $error("control read differs from last write");
    rsvd_zero_a: assert property (rd_ctl |-> !avs_readdata_o[6])
        else $error("reserved bit reads one");
    enable_gate_a: assert property ((!ctrl_ff[7]) [*3] |-> !ring_valid_o)
        else $error("ring valid while disabled");
    clear_idle_a: assert property ($fell(ctrl_ff[7]) |-> ##[1:2] !ring_valid_o)
        else $error("ring valid stays after disable");
    confirm_ev_a: assert property ($rose(ring_valid_o) |-> ev_ff == 2'd2)
        else $error("ring valid without qualifying events");
    end_gap_a: assert property (ring_valid_o |-> gap_ff < LIMIT)
        else $error("ring valid long after last event");
    wait_one_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("access not answered next cycle");
    ready_req_a: assert property (!avs_waitrequest_o |-> $past(req))
        else $error("ready without request");
    irq_mask_a: assert property (irq_o |-> $past(mask_ff) != 4'h0)
        else $error("interrupt with all sources masked");
    valid_c: cover property ($rose(ring_valid_o));
    irq_c: cover property ($rose(irq_o));
    end_c: cover property ($fell(ring_valid_o));
endmodule
bind ring_frequency_validator ring_freq_chk #(.STEP_CYC(STEP_CYC)) ring_freq_chk_i (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ring_event_i(ring_event_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ring_valid_o(ring_valid_o), .irq_o(irq_o));
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ring_freq_pkg::*;
    typedef struct packed {
        logic        we;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } row_s;
    logic        sys_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        run = 1'b0;
    logic [7:0]  gap = 8'h10;
    logic        ring_event_i;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o, q;
    logic        avs_waitrequest_o, ring_valid_o, irq_o;
    int          mismatches = 0;
    int          total_checks = 0;
    row_s rows [8] = '{'{1'b0, 8'h18, 32'h0, 32'h19}, '{1'b0, 8'h40, 32'h0, 32'h2d},
        '{1'b0, 8'h44, 32'h0, 32'h0c}, '{1'b0, 8'h50, 32'h0, 32'h00}, '{1'b1, 8'h18, 32'hbf, 32'h0},
        '{1'b0, 8'h18, 32'h0, 32'hbf}, '{1'b1, 8'h7c, 32'hff, 32'h0}, '{1'b0, 8'h7c, 32'h0, 32'h00}};
    always #12.5 sys_clk_i = ~sys_clk_i;
    ring_line_model ring_line_model_i (.sys_clk_i(sys_clk_i), .run_i(run), .gap_i(gap), .ring_event_o(ring_event_i));
    ring_frequency_validator #(.STEP_CYC(4)) ring_frequency_validator_i (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ring_event_i(ring_event_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ring_valid_o(ring_valid_o), .irq_o(irq_o));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= we;
        avs_read_i <= !we;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        if (n >= 100) chk("waitrequest", 32'h1, 32'h0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wait_valid(input logic lvl, input int lim);
        int n;
        n = 0;
        while (ring_valid_o !== lvl && n < lim) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask
    task automatic pulses(input logic [7:0] g, input int cyc);
        gap <= g;
        run <= 1'b1;
        repeat (cyc) @(posedge sys_clk_i);
        run <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].we, rows[i].a, rows[i].d);
            if (!rows[i].we) chk("register", q, rows[i].e);
        end
        $display("register table done");
        bus(1'b1, OFS_RING_MAX, 32'h02);
        bus(1'b1, OFS_IRQ_MASK, 32'h02);
        bus(1'b1, OFS_RING_VAL_CTRL2, 32'h08);
        bus(1'b1, OFS_RING_VAL_CTRL3, 32'h85);
        pulses(8'd40, 50);
        chk("irq_o low", {31'h0, irq_o}, 32'h1);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("too low", q & 32'h2, 32'h2);
        bus(1'b1, OFS_IRQ_STATUS, 32'h0f);
        repeat (3) @(posedge sys_clk_i);
        chk("irq_o cleared", {31'h0, irq_o}, 32'h0);
        $display("too low done");
        pulses(8'd2, 3);
        chk("irq_o masked", {31'h0, irq_o}, 32'h0);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("too high", q & 32'h4, 32'h4);
        bus(1'b1, OFS_IRQ_STATUS, 32'h0f);
        bus(1'b1, OFS_IRQ_MASK, 32'h0f);
        $display("too high done");
        gap <= 8'd16;
        run <= 1'b1;
        wait_valid(1'b1, 3000);
        chk("ring valid", {31'h0, ring_valid_o}, 32'h1);
        @(posedge sys_clk_i);
        chk("irq_o valid", {31'h0, irq_o}, 32'h1);
        run <= 1'b0;
        wait_valid(1'b0, 5000);
        chk("ring end", {31'h0, ring_valid_o}, 32'h0);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("valid and end", q & 32'h9, 32'h9);
        $display("valid ring done");
        run <= 1'b1;
        repeat (40) @(posedge sys_clk_i);
        bus(1'b0, OFS_RING_STATUS, 32'h0);
        chk("qualifying", q & 32'h3, 32'h1);
        bus(1'b1, OFS_RING_VAL_CTRL3, 32'h05);
        bus(1'b0, OFS_RING_STATUS, 32'h0);
        chk("idle", q & 32'h3, 32'h0);
        bus(1'b1, OFS_IRQ_STATUS, 32'h0f);
        repeat (300) @(posedge sys_clk_i);
        run <= 1'b0;
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("disabled events", q, 32'h0);
        $display("disable done");
        bus(1'b1, OFS_RING_VAL_CTRL3, 32'h85);
        reset_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        bus(1'b0, OFS_RING_VAL_CTRL3, 32'h0);
        chk("reset ctrl3", q, 32'h19);
        $display("reset done");
        test_done();
    end
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
